// ==== logic/dead_band_delay.sv ====
`timescale 1ns/1ps
module dead_band_delay (
   input  wire logic                                clk,
   input  wire logic                                rstSync_n,
   input  wire logic                                desiredActive,
   input  wire logic [pwm_deadband_pkg::DELAY_W-1:0] delayCount,
   output logic                                     delayedActive
);
   import pwm_deadband_pkg::*;

   localparam int CNT_W = DELAY_W + TCY_PHASE_W;

   logic [CNT_W-1:0] waitCnt_q;
   wire  [CNT_W-1:0] target;
   wire              zeroDelay;
   wire              reached;
   wire              active_d;
   wire  [CNT_W-1:0] waitCnt_d;

   assign target    = CNT_W'(CNT_W'(delayCount) * CNT_W'(OSC_PER_TCY)); // RL3
   assign zeroDelay = (delayCount == '0); // RL9
   // >= so a count lowered mid-wait still ends the wait
   assign reached   = zeroDelay || (waitCnt_q >= target); // RL3
   // falling edge passes at once, only the rise waits
   assign active_d  = desiredActive && (delayedActive || reached); // RL2
   assign waitCnt_d = (desiredActive && !delayedActive && !reached) ?
                      waitCnt_q + CNT_W'(1) : '0;

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         waitCnt_q     <= '0;
         delayedActive <= 1'b0;
      end else begin
         waitCnt_q     <= waitCnt_d;
         delayedActive <= active_d;
      end
   end

   sequence s_rise_one_tcy;
      $rose(desiredActive) && delayCount == 7'h01 ##1 desiredActive[*4];
   endsequence

   a_zero_delay_pass: assert property (@(posedge clk) disable iff (!rstSync_n) // RL9
      desiredActive && zeroDelay |=> delayedActive)
      else $error("zero delay did not pass the active edge");
   a_fall_no_delay: assert property (@(posedge clk) disable iff (!rstSync_n) // RL2
      !desiredActive |=> !delayedActive)
      else $error("inactive edge was delayed");
   a_rise_held_off: assert property (@(posedge clk) disable iff (!rstSync_n) // RL3
      $rose(desiredActive) && !zeroDelay |=> !delayedActive)
      else $error("active edge not delayed");
   a_one_tcy_lag: assert property (@(posedge clk) disable iff (!rstSync_n) // RL3
      s_rise_one_tcy |=> delayedActive)
      else $error("one instruction cycle delay wrong");
endmodule

// ==== logic/pwm_deadband_pkg.sv ====
package pwm_deadband_pkg;
   // register port
   localparam int         ADDR_W = 4;
   localparam int         DATA_W = 8;

   localparam logic [3:0] OFS_DUTY_LOW     = 4'h0;
   localparam logic [3:0] OFS_DUTY_SHADOW  = 4'h1;
   localparam logic [3:0] OFS_MODE         = 4'h2;
   localparam logic [3:0] OFS_SHUTDOWN     = 4'h3;
   localparam logic [3:0] OFS_PERIOD       = 4'h4;
   localparam logic [3:0] OFS_DEADBAND     = 4'h5;
   localparam logic [3:0] OFS_COUNTER      = 4'h6;
   localparam logic [3:0] OFS_IRQ_STATUS   = 4'h7;
   localparam logic [3:0] OFS_IRQ_MASK     = 4'h8;

   // pwm_mode_control fields
   localparam int         BRIDGE_POS   = 6;
   localparam int         DUTY_LSB_POS = 4;
   localparam int         PWM_SEL_POS  = 2;
   localparam int         AC_LOW_POS   = 1;
   localparam int         BD_LOW_POS   = 0;
   localparam logic [1:0] BRIDGE_HALF  = 2'h2;
   localparam logic [1:0] PWM_SEL_ON   = 2'h3;

   // auto_shutdown_control fields
   localparam int         EVENT_FLAG_POS = 7;
   localparam int         SRC_INT_POS    = 6;
   localparam int         SRC_AUX_POS    = 4;
   localparam int         PSS_AC_POS     = 2;
   localparam int         PSS_BD_POS     = 0;
   localparam logic [7:0] SHUT_WR_MASK   = 8'h5f;
   localparam logic [1:0] PSS_DRIVE_LOW  = 2'h0;
   localparam logic [1:0] PSS_DRIVE_HIGH = 2'h1;
   localparam int         PSS_TRI_POS    = 1;

   // deadband_restart_control fields
   localparam int         RESTART_POS = 7;
   localparam int         DELAY_W     = 7;

   // interrupt status / mask layout
   localparam int         IRQ_W           = 3;
   localparam int         IRQ_PERIOD_POS  = 0;
   localparam int         IRQ_SHUT_POS    = 1;
   localparam int         IRQ_RESTART_POS = 2;

   // reset values
   localparam logic [7:0] RST_DUTY     = 8'h00;
   localparam logic [7:0] RST_MODE     = 8'h00;
   localparam logic [7:0] RST_SHUTDOWN = 8'h00;
   localparam logic [7:0] RST_PERIOD   = 8'hff;
   localparam logic [7:0] RST_DEADBAND = 8'h00;
   localparam logic [7:0] RST_COUNTER  = 8'h00;

   // timing: clk is the oscillator, one instruction cycle is four of it
   localparam int         CLK_PERIOD_NS = 20;
   localparam int         OSC_PER_TCY   = 4;
   localparam int         TCY_PHASE_W   = 2;
   localparam logic [1:0] TCY_LAST      = 2'(OSC_PER_TCY - 1);

   typedef enum logic [1:0] {
      ST_RUN  = 2'b00,
      ST_SHUT = 2'b01,
      ST_WAIT = 2'b10
   } run_state_t;
endpackage

// ==== logic/pwm_deadband_restart_ctrl.sv ====
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
// Summary of operation
// RL1: half-bridge mode inserts a programmable dead band between complementary outputs.
// RL2: dead band delays only inactive-to-active edges; falling edges pass undelayed.
// RL3: seven-bit delay count gives the lag in instruction cycles of four clocks.
// RL4: restart enable set clears the shutdown flag by hardware once the event ends.
// RL5: restart enable clear keeps the flag set until software clears it.
// RL6: shutdown sets the flag and drives each pin pair to its chosen state.
// RL7: after restart the waveform resumes only at the next period start.
// RL8: software writes to the flag are ignored while shutdown persists.
// RL9: a delay count of zero adds no dead band at all.
module pwm_deadband_restart_ctrl (
   input  wire logic                                clk,
   input  wire logic                                rst_n,
   input  wire logic [pwm_deadband_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [pwm_deadband_pkg::DATA_W-1:0] regWdata,
   input  wire logic                                regWrite,
   input  wire logic                                regRead,
   output logic      [pwm_deadband_pkg::DATA_W-1:0] regRdata,
   input  wire logic                                shutdownInt_n,
   input  wire logic                                shutdownAux_n,
   output logic                                     pwmOutA,
   output logic                                     pwmOutAOe,
   output logic                                     pwmOutB,
   output logic                                     pwmOutBOe,
   output logic                                     irq
);
   import pwm_deadband_pkg::*;

   // pair output: {oe, level} from shutdown state field and run level
   function automatic logic [1:0] pairDrive(input logic       running,
                                            input logic [1:0] pss,
                                            input logic       runLevel);
      if (running)
         pairDrive = {1'b1, runLevel};
      else if (pss[PSS_TRI_POS])
         pairDrive = 2'b00;
      else if (pss == PSS_DRIVE_HIGH)
         pairDrive = 2'b11;
      else
         pairDrive = 2'b10;
   endfunction

   // reset release through two flops
   logic rstMeta_n;
   logic rstSync_n;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_n <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         rstMeta_n <= 1'b1;
         rstSync_n <= rstMeta_n;
      end
   end

   // registers
   logic [7:0]       dutyLow_q;
   logic [7:0]       modeCtrl_q;
   logic [6:0]       shutCtrl_q;
   logic             eventFlag_q;
   logic             eventFlag_d;
   logic [7:0]       period_q;
   logic [7:0]       deadCtrl_q;
   logic [7:0]       counter_q;
   logic [7:0]       counter_d;
   logic [1:0]       phase_q;
   logic [1:0]       phase_d;
   logic [9:0]       dutyLatch_q;
   logic             rawPwm_q;
   logic             rawPwm_d;
   logic [IRQ_W-1:0] irqStatus_q;
   logic [IRQ_W-1:0] irqStatus_d;
   logic [IRQ_W-1:0] irqMask_q;
   run_state_t       state_q;
   run_state_t       state_d;

   // address decode
   wire wrDutyLow = regWrite && (regAddr == OFS_DUTY_LOW);
   wire wrMode    = regWrite && (regAddr == OFS_MODE);
   wire wrShut    = regWrite && (regAddr == OFS_SHUTDOWN);
   wire wrPeriod  = regWrite && (regAddr == OFS_PERIOD);
   wire wrDead    = regWrite && (regAddr == OFS_DEADBAND);
   wire wrCounter = regWrite && (regAddr == OFS_COUNTER);
   wire wrMask    = regWrite && (regAddr == OFS_IRQ_MASK);
   wire rdStatus  = regRead && (regAddr == OFS_IRQ_STATUS);

   // mode fields
   wire       pwmEnabled  = (modeCtrl_q[PWM_SEL_POS +: 2] == PWM_SEL_ON);
   wire       halfBridge  = (modeCtrl_q[BRIDGE_POS +: 2] == BRIDGE_HALF);
   wire       acActiveLow = modeCtrl_q[AC_LOW_POS];
   wire       bdActiveLow = modeCtrl_q[BD_LOW_POS];
   wire       restartAuto = deadCtrl_q[RESTART_POS];
   wire [6:0] deadCount   = deadCtrl_q[DELAY_W-1:0];
   wire [1:0] pair_a_c_shutdown_state       = shutCtrl_q[PSS_AC_POS +: 2];
   wire [1:0] pair_b_d_shutdown_state       = shutCtrl_q[PSS_BD_POS +: 2];

   // shutdown is a level: low pin on an enabled source
   wire shutCond = (shutCtrl_q[SRC_INT_POS] && !shutdownInt_n) ||
                   (shutCtrl_q[SRC_AUX_POS] && !shutdownAux_n);

   // 10-bit timebase: counter byte above the oscillator phase
   wire       periodEnd = pwmEnabled && (phase_q == TCY_LAST) && (counter_q == period_q);
   wire [9:0] dutyNew   = {dutyLow_q, modeCtrl_q[DUTY_LSB_POS +: 2]};
   wire [9:0] timeNext  = {counter_d, phase_d};

   always_comb begin
      phase_d   = phase_q;
      counter_d = counter_q;
      if (pwmEnabled) begin
         phase_d = phase_q + 2'h1;
         if (periodEnd)
            counter_d = 8'h00;
         else if (phase_q == TCY_LAST)
            counter_d = counter_q + 8'h01;
      end
      // software load of the counter takes over the increment
      if (wrCounter)
         counter_d = regWdata;
   end

   // duty larger than the period leaves the raw level high
   assign rawPwm_d = periodEnd ? (dutyNew != 10'h000) :
                     (timeNext == dutyLatch_q) ? 1'b0 : rawPwm_q;

   // shutdown flag: the condition wins over software, software over auto clear
   always_comb begin
      eventFlag_d = eventFlag_q;
      if (shutCond)
         eventFlag_d = 1'b1; // RL6 RL8
      else if (wrShut)
         eventFlag_d = regWdata[EVENT_FLAG_POS]; // RL5
      else if (restartAuto && eventFlag_q)
         eventFlag_d = 1'b0; // RL4
   end

   // output run state: leaving shutdown waits for a fresh period
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RUN:  if (eventFlag_q) state_d = ST_SHUT;
         ST_SHUT: if (!eventFlag_q) state_d = ST_WAIT;
         ST_WAIT: begin
            if (eventFlag_q)
               state_d = ST_SHUT;
            else if (periodEnd)
               state_d = ST_RUN; // RL7
         end
         default: state_d = ST_RUN;
      endcase
   end

   // dead band on each leg, only in half-bridge mode
   logic      activeA;
   logic      activeB;
   wire [6:0] legDelay = halfBridge ? deadCount : 7'h00; // RL1

   dead_band_delay legA (
      .clk           (clk),
      .rstSync_n     (rstSync_n),
      .desiredActive (rawPwm_q),
      .delayCount    (legDelay),
      .delayedActive (activeA)
   );

   dead_band_delay legB (
      .clk           (clk),
      .rstSync_n     (rstSync_n),
      .desiredActive (halfBridge && !rawPwm_q), // RL1
      .delayCount    (legDelay),
      .delayedActive (activeB)
   );

   wire       running = (state_q == ST_RUN);
   wire [1:0] driveA  = pairDrive(running, pair_a_c_shutdown_state, activeA ^ acActiveLow); // RL6
   wire [1:0] driveB  = pairDrive(running, pair_b_d_shutdown_state, activeB ^ bdActiveLow); // RL6

   // interrupt events; a read clears, but a same-cycle event survives
   wire [IRQ_W-1:0] irqEvents;
   assign irqEvents[IRQ_PERIOD_POS]  = periodEnd;
   assign irqEvents[IRQ_SHUT_POS]    = eventFlag_d && !eventFlag_q;
   assign irqEvents[IRQ_RESTART_POS] = (state_q == ST_WAIT) && (state_d == ST_RUN);
   assign irqStatus_d = (rdStatus ? '0 : irqStatus_q) | irqEvents;

   // read mux
   wire [7:0] shutRead = {eventFlag_q, shutCtrl_q[6], 1'b0, shutCtrl_q[4:0]};
   wire [7:0] rdData;
   assign rdData = (regAddr == OFS_DUTY_LOW)    ? dutyLow_q :
                   (regAddr == OFS_DUTY_SHADOW) ? dutyLatch_q[9:2] :
                   (regAddr == OFS_MODE)        ? modeCtrl_q :
                   (regAddr == OFS_SHUTDOWN)    ? shutRead :
                   (regAddr == OFS_PERIOD)      ? period_q :
                   (regAddr == OFS_DEADBAND)    ? deadCtrl_q :
                   (regAddr == OFS_COUNTER)     ? counter_q :
                   (regAddr == OFS_IRQ_STATUS)  ? 8'(irqStatus_q) :
                   (regAddr == OFS_IRQ_MASK)    ? 8'(irqMask_q) : 8'h00;

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         dutyLow_q  <= RST_DUTY;
         modeCtrl_q <= RST_MODE;
         shutCtrl_q <= RST_SHUTDOWN[6:0];
         period_q   <= RST_PERIOD;
         deadCtrl_q <= RST_DEADBAND;
         irqMask_q  <= '0;
      end else begin
         if (wrDutyLow) dutyLow_q <= regWdata;
         if (wrMode) modeCtrl_q <= regWdata;
         if (wrShut) shutCtrl_q <= regWdata[6:0] & SHUT_WR_MASK[6:0];
         if (wrPeriod) period_q <= regWdata;
         if (wrDead) deadCtrl_q <= regWdata; // RL3 RL4
         if (wrMask) irqMask_q <= regWdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         counter_q   <= RST_COUNTER;
         phase_q     <= 2'h0;
         dutyLatch_q <= 10'h000;
         rawPwm_q    <= 1'b0;
         eventFlag_q <= RST_SHUTDOWN[EVENT_FLAG_POS];
         state_q     <= ST_RUN;
      end else begin
         counter_q   <= counter_d;
         phase_q     <= phase_d;
         if (periodEnd) dutyLatch_q <= dutyNew;
         rawPwm_q    <= rawPwm_d;
         eventFlag_q <= eventFlag_d;
         state_q     <= state_d;
      end
   end

   // every output from a flop; disabled pwm releases both pins
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         pwmOutA     <= 1'b0;
         pwmOutAOe   <= 1'b0;
         pwmOutB     <= 1'b0;
         pwmOutBOe   <= 1'b0;
         irqStatus_q <= '0;
         irq         <= 1'b0;
         regRdata    <= 8'h00;
      end else begin
         pwmOutAOe   <= pwmEnabled && driveA[1];
         pwmOutA     <= pwmEnabled && driveA[0];
         pwmOutBOe   <= pwmEnabled && halfBridge && driveB[1];
         pwmOutB     <= pwmEnabled && halfBridge && driveB[0];
         irqStatus_q <= irqStatus_d;
         irq         <= |(irqStatus_d & irqMask_q);
         regRdata    <= regRead ? rdData : 8'h00;
      end
   end

   sequence s_restart_wait;
      state_q == ST_WAIT && !periodEnd;
   endsequence

   a_legs_never_both: assert property (@(posedge clk) disable iff (!rstSync_n) // RL1
      !(activeA && activeB))
      else $error("both legs active together");
   a_shut_sets_flag: assert property (@(posedge clk) disable iff (!rstSync_n) // RL6
      shutCond |=> eventFlag_q ##1 state_q == ST_SHUT)
      else $error("shutdown did not set the flag and stop");
   a_shut_pin_low: assert property (@(posedge clk) disable iff (!rstSync_n) // RL6
      !running && pwmEnabled && pair_a_c_shutdown_state == PSS_DRIVE_LOW |=> pwmOutAOe && !pwmOutA)
      else $error("pair a drive low state wrong");
   a_write_ignored: assert property (@(posedge clk) disable iff (!rstSync_n) // RL8
      shutCond && wrShut && !regWdata[EVENT_FLAG_POS] |=> eventFlag_q)
      else $error("flag cleared during shutdown");
   a_auto_clear: assert property (@(posedge clk) disable iff (!rstSync_n) // RL4
      eventFlag_q && restartAuto && !shutCond && !wrShut |=> !eventFlag_q)
      else $error("auto restart did not clear the flag");
   a_manual_hold: assert property (@(posedge clk) disable iff (!rstSync_n) // RL5
      eventFlag_q && !restartAuto && !wrShut |=> eventFlag_q)
      else $error("flag cleared without software");
   a_resume_period: assert property (@(posedge clk) disable iff (!rstSync_n) // RL7
      s_restart_wait |=> state_q != ST_RUN)
      else $error("restart before period start");
   a_resume_on_end: assert property (@(posedge clk) disable iff (!rstSync_n) // RL7
      state_q == ST_WAIT && periodEnd && !eventFlag_q |=> running ##1 pwmOutAOe)
      else $error("restart missed the period start");

   // legs: a count lowered mid-wait still leaves four clocks, only zero cuts it
   a_half_only_b: assert property (@(posedge clk) disable iff (!rstSync_n) // RL1
      !halfBridge |=> !pwmOutBOe && !activeB)
      else $error("leg b active outside half-bridge mode");
   a_fall_a_at_once: assert property (@(posedge clk) disable iff (!rstSync_n) // RL2
      $fell(rawPwm_q) |=> !activeA)
      else $error("leg a inactive edge delayed");
   a_fall_b_at_once: assert property (@(posedge clk) disable iff (!rstSync_n) // RL2
      $rose(rawPwm_q) |=> !activeB)
      else $error("leg b inactive edge delayed");
   a_dead_gap_a: assert property (@(posedge clk) disable iff (!rstSync_n) // RL3
      $rose(rawPwm_q) && legDelay != 7'h00 |=> (!activeA)[*4])
      else $error("leg a dead band too short");
   a_dead_gap_b: assert property (@(posedge clk) disable iff (!rstSync_n) // RL3
      $fell(rawPwm_q) && legDelay != 7'h00 |=> (!activeB)[*4])
      else $error("leg b dead band too short");
   a_zero_lag_a: assert property (@(posedge clk) disable iff (!rstSync_n) // RL9
      $rose(rawPwm_q) && legDelay == 7'h00 |=> activeA)
      else $error("leg a lagged with zero count");
   a_zero_lag_b: assert property (@(posedge clk) disable iff (!rstSync_n) // RL9
      $fell(rawPwm_q) && halfBridge && legDelay == 7'h00 |=> activeB)
      else $error("leg b lagged with zero count");

   // shutdown and restart
   sequence s_auto_release;
      state_q == ST_SHUT && eventFlag_q && restartAuto && !shutCond && !wrShut;
   endsequence

   a_auto_resume: assert property (@(posedge clk) disable iff (!rstSync_n) // RL4
      s_auto_release |=> !eventFlag_q ##1 state_q == ST_WAIT)
      else $error("auto restart did not leave shutdown");
   a_sw_clear: assert property (@(posedge clk) disable iff (!rstSync_n) // RL5
      eventFlag_q && !shutCond && wrShut && !regWdata[EVENT_FLAG_POS] |=> !eventFlag_q)
      else $error("software clear of the flag lost");
   a_manual_stays: assert property (@(posedge clk) disable iff (!rstSync_n) // RL5
      state_q == ST_SHUT && eventFlag_q && !restartAuto && !wrShut |=> state_q == ST_SHUT)
      else $error("manual mode left shutdown alone");
   a_flag_stops_run: assert property (@(posedge clk) disable iff (!rstSync_n) // RL6
      state_q == ST_RUN && eventFlag_q |=> state_q == ST_SHUT)
      else $error("flag did not stop the outputs");
   a_flag_stops_wait: assert property (@(posedge clk) disable iff (!rstSync_n) // RL6
      state_q == ST_WAIT && eventFlag_q |=> state_q == ST_SHUT)
      else $error("flag during wait did not stop the outputs");
   a_shut_pin_high: assert property (@(posedge clk) disable iff (!rstSync_n) // RL6
      !running && pwmEnabled && pair_a_c_shutdown_state == PSS_DRIVE_HIGH |=> pwmOutAOe && pwmOutA)
      else $error("pair a drive high state wrong");
   a_shut_b_low: assert property (@(posedge clk) disable iff (!rstSync_n) // RL6
      !running && pwmEnabled && halfBridge && pair_b_d_shutdown_state == PSS_DRIVE_LOW |=> pwmOutBOe && !pwmOutB)
      else $error("pair b drive low state wrong");
   a_shut_a_float: assert property (@(posedge clk) disable iff (!rstSync_n) // RL6
      !running && pair_a_c_shutdown_state[PSS_TRI_POS] |=> !pwmOutAOe)
      else $error("pair a not released");
   a_shut_b_float: assert property (@(posedge clk) disable iff (!rstSync_n) // RL6
      !running && pair_b_d_shutdown_state[PSS_TRI_POS] |=> !pwmOutBOe)
      else $error("pair b not released");
   a_pins_released: assert property (@(posedge clk) disable iff (!rstSync_n) // RL6
      !pwmEnabled |=> !pwmOutAOe && !pwmOutBOe)
      else $error("pins driven with pwm off");
endmodule

// ==== tb/bridge_driver_model.sv ====
`timescale 1ns/1ps
module bridge_driver_model (
   input  wire logic       clk,
   input  wire logic       pwmOutA,
   input  wire logic       pwmOutAOe,
   input  wire logic       pwmOutB,
   input  wire logic       pwmOutBOe,
   input  wire logic [1:0] faultCmd,
   output logic            shutdownInt_n,
   output logic            shutdownAux_n,
   output int              overlapCount
);
   // a gate whose pin floats is taken as off, the drivers pull it down
   wire highOn = pwmOutAOe & pwmOutA;
   wire lowOn  = pwmOutBOe & pwmOutB;
   int  overlapSeen = 0;

   assign overlapCount = overlapSeen;

   // fault detectors answer one clock after the bench commands a fault
   always @(posedge clk) begin
      shutdownInt_n <= ~faultCmd[0];
      shutdownAux_n <= ~faultCmd[1];
      if (highOn && lowOn) begin
         overlapSeen <= overlapSeen + 1;
      end
   end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
   import pwm_deadband_pkg::*;
   logic       clk;
   logic       rst_n;
   logic [3:0] regAddr;
   logic [7:0] regWdata;
   logic       regWrite;
   logic       regRead;
   logic [7:0] regRdata;
   logic [1:0] faultCmd;
   logic       shutdownInt_n;
   logic       shutdownAux_n;
   logic       pwmOutA;
   logic       pwmOutAOe;
   logic       pwmOutB;
   logic       pwmOutBOe;
   logic       irq;
   int         overlapCount;
   int         n_fail;
   int         tests_run;
   logic       dirB;
   logic [7:0] rv;
   int         g;
   int         n;
   int         dl[3] = '{0, 1, 127};
   logic [7:0] rstExp[9] = '{RST_DUTY, 8'h00, RST_MODE, RST_SHUTDOWN, RST_PERIOD,
                             RST_DEADBAND, RST_COUNTER, 8'h00, 8'h00};
   wire        leadSig = dirB ? pwmOutB : pwmOutA;
   wire        lagSig  = dirB ? pwmOutA : pwmOutB;

   pwm_deadband_restart_ctrl pwm_deadband_restart_ctrl_i (
      .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .shutdownInt_n(shutdownInt_n), .shutdownAux_n(shutdownAux_n),
      .pwmOutA(pwmOutA), .pwmOutAOe(pwmOutAOe), .pwmOutB(pwmOutB),
      .pwmOutBOe(pwmOutBOe), .irq(irq));

   bridge_driver_model bridge_driver_model_i (
      .clk(clk), .pwmOutA(pwmOutA), .pwmOutAOe(pwmOutAOe), .pwmOutB(pwmOutB),
      .pwmOutBOe(pwmOutBOe), .faultCmd(faultCmd), .shutdownInt_n(shutdownInt_n),
      .shutdownAux_n(shutdownAux_n), .overlapCount(overlapCount));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask

   // data stand only in the cycle after the taking edge
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      d = regRdata;
   endtask

   // from a falling lead pin, clocks until the opposite pin turns active
   task automatic edgeGap(input logic b, output int gap);
      logic prevLead;
      dirB = b;
      #1;
      prevLead = leadSig;
      gap = 0;
      repeat (2100) begin
         @(posedge clk);
         #1;
         if (prevLead === 1'b1 && leadSig === 1'b0) break;
         prevLead = leadSig;
      end
      while (lagSig !== 1'b1 && gap < 600) begin
         @(posedge clk);
         #1;
         gap++;
      end
   endtask

   task automatic waitCycles(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      final_report();
   end

   initial begin
      n_fail = 0;
      tests_run = 0;
      dirB = 1'b0;
      rst_n = 1'b0;
      regAddr = 4'h0;
      regWdata = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      faultCmd = 2'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);

      for (int i = 0; i < 9; i++) begin
         rd(4'(i), rv);
         chk(rv, rstExp[i]);
      end
      rd(4'hf, rv);
      chk(rv, 8'h00);
      wr(OFS_DUTY_SHADOW, 8'h5a);
      rd(OFS_DUTY_SHADOW, rv);
      chk(rv, 8'h00);
      wr(OFS_DEADBAND, 8'h81);
      rd(OFS_DEADBAND, rv);
      chk(rv, 8'h81);
      wr(OFS_SHUTDOWN, 8'h3f);
      rd(OFS_SHUTDOWN, rv);
      chk(rv, 8'h1f);
      wr(OFS_SHUTDOWN, 8'h00);
      $display("test registers done");

      // 1024-clock period, half duty, half-bridge, active-high pins
      wr(OFS_DUTY_LOW, 8'h80);
      wr(OFS_MODE, 8'h8c);
      wr(OFS_IRQ_MASK, 8'h02);
      for (int i = 0; i < 3; i++) begin
         wr(OFS_DEADBAND, 8'(dl[i]));
         edgeGap(1'b0, g);
         chk(g, 4 * dl[i]);
         edgeGap(1'b1, g);
         chk(g, 4 * dl[i]);
      end
      chk({pwmOutAOe, pwmOutBOe}, 2'b11);
      chk(overlapCount, 0);
      chk(irq, 1'b0);
      rd(OFS_DUTY_SHADOW, rv);
      chk(rv, 8'h80);
      $display("test dead band done");

      // manual restart: pair A drives 0, pair B floats
      rd(OFS_IRQ_STATUS, rv);
      wr(OFS_SHUTDOWN, 8'h42);
      faultCmd <= 2'h1;
      waitCycles(6);
      chk({pwmOutA, pwmOutAOe, pwmOutBOe}, 3'b010);
      chk(irq, 1'b1);
      rd(OFS_IRQ_STATUS, rv);
      chk(rv & 8'h02, 8'h02);
      waitCycles(2);
      chk(irq, 1'b0);
      wr(OFS_SHUTDOWN, 8'h42);
      rd(OFS_SHUTDOWN, rv);
      chk(rv, 8'hc2);
      faultCmd <= 2'h0;
      waitCycles(20);
      rd(OFS_SHUTDOWN, rv);
      chk(rv, 8'hc2);
      chk(pwmOutBOe, 1'b0);
      wr(OFS_SHUTDOWN, 8'h42);
      wr(OFS_COUNTER, 8'h00);
      n = 0;
      while (pwmOutBOe !== 1'b1 && n < 1100) begin
         waitCycles(1);
         n++;
      end
      chk(n >= 1000 && n <= 1040, 1'b1);
      rd(OFS_IRQ_STATUS, rv);
      chk(rv & 8'h05, 8'h05);
      $display("test manual restart done");

      // auto restart from the second source: pair A drives 1, pair B drives 0
      wr(OFS_DEADBAND, 8'h81);
      wr(OFS_SHUTDOWN, 8'h14);
      faultCmd <= 2'h2;
      waitCycles(6);
      chk({pwmOutA, pwmOutAOe, pwmOutB, pwmOutBOe}, 4'b1101);
      rd(OFS_SHUTDOWN, rv);
      chk(rv, 8'h94);
      faultCmd <= 2'h0;
      waitCycles(4);
      rd(OFS_SHUTDOWN, rv);
      chk(rv, 8'h14);
      n = 0;
      while (pwmOutA !== 1'b0 && n < 2100) begin
         waitCycles(1);
         n++;
      end
      chk(n < 2100, 1'b1);
      chk(overlapCount, 0);
      $display("test auto restart done");
      final_report();
   end
endmodule
